// ===== core/gex_pkg.sv
// Register map, reset values and state layout of the GPIO expander
package gex_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int GEX_PINS = 8;
    localparam int GEX_CODE_W = 2;
    localparam int GEX_PTR_W = 8;

    // ------------------------------------------------------------
    // Register offsets (command byte values)
    // ------------------------------------------------------------
    localparam logic [7:0] GEX_PIN_LEVEL = 8'h00;
    localparam logic [7:0] GEX_OUTPUT_LEVEL = 8'h01;
    localparam logic [7:0] GEX_INPUT_INVERT = 8'h02;
    localparam logic [7:0] GEX_PIN_DIRECTION = 8'h03;
    localparam logic [7:0] GEX_DRIVE_STRENGTH_LOW = 8'h40;
    localparam logic [7:0] GEX_DRIVE_STRENGTH_HIGH = 8'h41;
    localparam logic [7:0] GEX_LATCH_SELECT = 8'h42;
    localparam logic [7:0] GEX_PULL_ENABLE = 8'h43;
    localparam logic [7:0] GEX_PULL_DIRECTION = 8'h44;
    localparam logic [7:0] GEX_IRQ_MASK = 8'h45;
    localparam logic [7:0] GEX_IRQ_SOURCE = 8'h46;
    localparam logic [7:0] GEX_OUTPUT_STAGE_SELECT = 8'h4f;

    // Pointer bit that selects the extended bank
    localparam int GEX_EXT_BIT = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GEX_RST_OUTPUT_LEVEL = 8'hff;
    localparam logic [7:0] GEX_RST_INPUT_INVERT = 8'h00;
    localparam logic [7:0] GEX_RST_PIN_DIRECTION = 8'hff;
    localparam logic [7:0] GEX_RST_DRIVE_STRENGTH = 8'hff;
    localparam logic [7:0] GEX_RST_LATCH_SELECT = 8'h00;
    localparam logic [7:0] GEX_RST_PULL_ENABLE = 8'h00;
    localparam logic [7:0] GEX_RST_PULL_DIRECTION = 8'hff;
    localparam logic [7:0] GEX_RST_IRQ_MASK = 8'hff;
    localparam logic [7:0] GEX_RST_ZERO = 8'h00;

    // Open-drain select sits in bit 0 of its register
    localparam int GEX_OPEN_DRAIN_BIT = 0;

    // ------------------------------------------------------------
    // Complete state of the register block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] output_level;
        logic [7:0] input_invert;
        logic [7:0] pin_direction;
        logic [15:0] drive_strength;
        logic [7:0] latch_select;
        logic [7:0] pull_enable;
        logic [7:0] pull_direction;
        logic [7:0] irq_mask;
        logic open_drain_select;
        logic [7:0] ref_level;
        logic [7:0] cap_valid;
        logic [7:0] cap_level;
        logic [7:0] snap_level;
        logic snap_is_pin_level;
        logic scl_prev;
        logic [7:0] rd_data;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] pull_connect;
        logic [7:0] pull_up;
        logic [15:0] strength_code;
        logic int_oe;
    } gex_state_t;

endpackage

// ===== core/gex_regs.sv
// Register set, pin control and change interrupt of the 8-bit GPIO expander
`timescale 1ns/1ps
module gex_regs
    import gex_pkg::*;
#(
    parameter int PINS = GEX_PINS,
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reset_pin_n,
    input wire logic scl,
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_data,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    input wire logic rd_ack_phase,
    output logic [7:0] rd_data,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pull_connect,
    output logic [PINS-1:0] pull_up,
    output logic [2*PINS-1:0] strength_code,
    output logic int_n_oe
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (PINS != GEX_PINS) begin : g_bad_pins
        $error("gex_regs register map serves exactly eight pins");
    end

    // ------------------------------------------------------------
    // Synchronisers for pins, serial clock and reset pin
    // ------------------------------------------------------------
    logic [PINS-1:0] pin_s;
    logic scl_s;
    logic reset_pin_n_s;

    // Port pins into the clock domain
    gex_sync #(
        .WIDTH(PINS),
        .STAGES(SYNC_STAGES),
        .INIT('0)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(pin_in),
        .q(pin_s)
    );

    // Serial clock and reset pin share one two-bit synchroniser
    gex_sync #(
        .WIDTH(2),
        .STAGES(SYNC_STAGES),
        .INIT(2'h3)
    ) u_ctl_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({scl, reset_pin_n}),
        .q({scl_s, reset_pin_n_s})
    );

    gex_state_t s_q;
    gex_state_t s_d;

    // ------------------------------------------------------------
    // Per-pin change detection and reported level
    // ------------------------------------------------------------
    logic [PINS-1:0] is_input;
    logic [PINS-1:0] raw_level;
    logic [PINS-1:0] level_now;
    logic [PINS-1:0] pending;
    logic [PINS-1:0] irq_source;
    logic [PINS-1:0] new_capture;

    assign is_input = s_q.pin_direction;

    // One slice of change logic per port pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        // Captured level shown only while the pin is still latched
        assign raw_level[i] = (s_q.cap_valid[i] & s_q.latch_select[i])
            ? s_q.cap_level[i]
            : pin_s[i];
        // Inversion applies to input pins only
        assign level_now[i] = raw_level[i] ^ (s_q.input_invert[i] & is_input[i]);
        // A held capture or a live difference from reference is pending
        assign pending[i] = is_input[i]
            & (s_q.cap_valid[i] | (pin_s[i] != s_q.ref_level[i]));
        // Masked pins never show as a source
        assign irq_source[i] = pending[i] & ~s_q.irq_mask[i];
        // Latched input that moved away from reference captures new level
        assign new_capture[i] = is_input[i] & s_q.latch_select[i] & ~s_q.cap_valid[i]
            & (pin_s[i] != s_q.ref_level[i]);
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    logic [7:0] read_value;

    // Pointer decode; pointer itself has no read path
    always_comb begin
        if (s_q.ptr == GEX_PIN_LEVEL) begin
            // Live or captured pin levels, inverted where asked
            read_value = level_now;
        end else if (s_q.ptr == GEX_OUTPUT_LEVEL) begin
            // Stored output levels, not the pins
            read_value = s_q.output_level;
        end else if (s_q.ptr == GEX_INPUT_INVERT) begin
            // Invert bits
            read_value = s_q.input_invert;
        end else if (s_q.ptr == GEX_PIN_DIRECTION) begin
            // Direction bits
            read_value = s_q.pin_direction;
        end else if (s_q.ptr == GEX_DRIVE_STRENGTH_LOW) begin
            // Strength codes of pins 0 to 3
            read_value = s_q.drive_strength[7:0];
        end else if (s_q.ptr == GEX_DRIVE_STRENGTH_HIGH) begin
            // Strength codes of pins 4 to 7
            read_value = s_q.drive_strength[15:8];
        end else if (s_q.ptr == GEX_LATCH_SELECT) begin
            // Latch select bits
            read_value = s_q.latch_select;
        end else if (s_q.ptr == GEX_PULL_ENABLE) begin
            // Pull enable bits
            read_value = s_q.pull_enable;
        end else if (s_q.ptr == GEX_PULL_DIRECTION) begin
            // Pull direction bits
            read_value = s_q.pull_direction;
        end else if (s_q.ptr == GEX_IRQ_MASK) begin
            // Mask bits
            read_value = s_q.irq_mask;
        end else if (s_q.ptr == GEX_IRQ_SOURCE) begin
            // Unmasked pending pins
            read_value = irq_source;
        end else if (s_q.ptr == GEX_OUTPUT_STAGE_SELECT) begin
            // Stage select with reserved bits as zero
            read_value = {7'h00, s_q.open_drain_select};
        end else begin
            // Holes in the map read as zero
            read_value = GEX_RST_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic scl_rise;
    logic read_clear;
    logic [PINS-1:0] clear_ref;

    // Serial clock rise, idle level high after reset
    assign scl_rise = scl_s & ~s_q.scl_prev;
    // Clear happens on the acknowledge bit of a pin level read
    assign read_clear = rd_ack_phase & scl_rise & s_q.snap_is_pin_level;
    // Held captures re-arm on the live level, others on what was reported
    assign clear_ref = (s_q.snap_level & ~s_q.cap_valid) | (pin_s & s_q.cap_valid);

    always_comb begin
        s_d = s_q;
        s_d.scl_prev = scl_s;

        // Command byte loads the pointer
        if (ptr_wr) begin
            s_d.ptr = ptr_data;
        end

        // Register writes decoded from the pointer
        if (wr_stb) begin
            if (s_q.ptr == GEX_OUTPUT_LEVEL) begin
                // Levels for output pins
                s_d.output_level = wr_data;
            end else if (s_q.ptr == GEX_INPUT_INVERT) begin
                // Input polarity
                s_d.input_invert = wr_data;
            end else if (s_q.ptr == GEX_PIN_DIRECTION) begin
                // Pin directions
                s_d.pin_direction = wr_data;
            end else if (s_q.ptr == GEX_DRIVE_STRENGTH_LOW) begin
                // Strength codes of pins 0 to 3
                s_d.drive_strength[7:0] = wr_data;
            end else if (s_q.ptr == GEX_DRIVE_STRENGTH_HIGH) begin
                // Strength codes of pins 4 to 7
                s_d.drive_strength[15:8] = wr_data;
            end else if (s_q.ptr == GEX_LATCH_SELECT) begin
                // Latch selects; held captures stay pending
                s_d.latch_select = wr_data;
            end else if (s_q.ptr == GEX_PULL_ENABLE) begin
                // Pull enables
                s_d.pull_enable = wr_data;
            end else if (s_q.ptr == GEX_PULL_DIRECTION) begin
                // Pull directions
                s_d.pull_direction = wr_data;
            end else if (s_q.ptr == GEX_IRQ_MASK) begin
                // Masks take effect on the next edge
                s_d.irq_mask = wr_data;
            end else if (s_q.ptr == GEX_OUTPUT_STAGE_SELECT) begin
                // Only the stage select bit is stored
                s_d.open_drain_select = wr_data[GEX_OPEN_DRAIN_BIT];
            end
            // Pin level, source and unlisted pointers ignore writes
        end

        // Byte load for transmit: answer and remember what was reported
        if (rd_stb) begin
            s_d.rd_data = read_value;
            s_d.snap_level = raw_level;
            s_d.snap_is_pin_level = (s_q.ptr == GEX_PIN_LEVEL);
        end

        // Latched inputs capture a change and hold it
        for (int i = 0; i < PINS; i++) begin
            if (new_capture[i]) begin
                s_d.cap_valid[i] = 1'b1;
                s_d.cap_level[i] = pin_s[i];
            end
        end

        // Read clear: reference becomes the level that was reported, or the live level for held captures,
        // so a change after the byte was loaded stays pending unless a capture holds it
        if (read_clear) begin
            s_d.ref_level = clear_ref;
            // A capture that differs from the new reference is a fresh change
            s_d.cap_valid = new_capture & (pin_s ^ s_q.snap_level);
        end

        // Registered pin controls
        // Output level goes to the pad unchanged
        s_d.pin_out = s_d.output_level;
        // Open-drain stages drive only the low level
        s_d.pin_oe = ~s_d.pin_direction
            & ~({PINS{s_d.open_drain_select}} & s_d.output_level);
        // Resistors stay off on open-drain output pins
        s_d.pull_connect = s_d.pull_enable
            & ~(~s_d.pin_direction & {PINS{s_d.open_drain_select}});
        // Pull direction only matters while connected
        s_d.pull_up = s_d.pull_direction;
        // Two bits per pin, pin n at bits 2n+1 and 2n
        s_d.strength_code = s_d.drive_strength;
        // Any unmasked pending pin pulls the line
        s_d.int_oe = |irq_source;

        // Reset pin returns everything to defaults
        if (!reset_pin_n_s) begin
            // Clear everything, then load the non-zero defaults
            s_d = '0;
            // Keep edge history so release brings no false rise
            s_d.scl_prev = scl_s;
            // Register defaults
            s_d.output_level = GEX_RST_OUTPUT_LEVEL;
            s_d.pin_direction = GEX_RST_PIN_DIRECTION;
            s_d.drive_strength = {GEX_RST_DRIVE_STRENGTH, GEX_RST_DRIVE_STRENGTH};
            s_d.pull_direction = GEX_RST_PULL_DIRECTION;
            s_d.irq_mask = GEX_RST_IRQ_MASK;
            // Present pins become the reference, so nothing is pending
            s_d.ref_level = pin_s;
            // Pin controls follow the defaults at once
            s_d.pin_out = GEX_RST_OUTPUT_LEVEL;
            s_d.pull_up = GEX_RST_PULL_DIRECTION;
            s_d.strength_code = {GEX_RST_DRIVE_STRENGTH, GEX_RST_DRIVE_STRENGTH};
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Constants only; zero first, then defaults
            s_q <= '0;
            // Serial clock idles high
            s_q.scl_prev <= 1'b1;
            // Register defaults
            s_q.output_level <= GEX_RST_OUTPUT_LEVEL;
            s_q.input_invert <= GEX_RST_INPUT_INVERT;
            s_q.pin_direction <= GEX_RST_PIN_DIRECTION;
            s_q.drive_strength <= {GEX_RST_DRIVE_STRENGTH, GEX_RST_DRIVE_STRENGTH};
            s_q.latch_select <= GEX_RST_LATCH_SELECT;
            s_q.pull_enable <= GEX_RST_PULL_ENABLE;
            s_q.pull_direction <= GEX_RST_PULL_DIRECTION;
            s_q.irq_mask <= GEX_RST_IRQ_MASK;
            // Pin controls matching the defaults
            s_q.pin_out <= GEX_RST_OUTPUT_LEVEL;
            s_q.pull_up <= GEX_RST_PULL_DIRECTION;
            s_q.strength_code <= {GEX_RST_DRIVE_STRENGTH, GEX_RST_DRIVE_STRENGTH};
        end else if (ce) begin
            // Clock enable low freezes all state
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data = s_q.rd_data;
    assign pin_out = s_q.pin_out;
    assign pin_oe = s_q.pin_oe;
    assign pull_connect = s_q.pull_connect;
    assign pull_up = s_q.pull_up;
    assign strength_code = s_q.strength_code;
    assign int_n_oe = s_q.int_oe;

endmodule

// ===== core/gex_sync.sv
// Level synchroniser of STAGES stages, two by default, for signals from outside the clock domain
`timescale 1ns/1ps
module gex_sync #(
    parameter int WIDTH = 8,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("gex_sync needs at least two stages");
    end

    logic [STAGES-1:0][WIDTH-1:0] chain_q;

    // Shift chain; only the last stage is visible
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chain_q <= {STAGES{INIT}};
        end else if (ce) begin
            chain_q <= {chain_q[STAGES-2:0], d};
        end
    end

    assign q = chain_q[STAGES-1];

endmodule

// ===== test/gex_chk.sv
// Port-level assertion checker for the GPIO expander register block
`timescale 1ns/1ps
module gex_chk #(
    parameter int PINS = 8,
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_data,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    input wire logic rd_ack_phase,
    input wire logic [7:0] rd_data,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pull_up,
    input wire logic [2*PINS-1:0] strength_code,
    input wire logic int_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] live_q;
    logic [2:0] ev_q;
    logic unl;
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Cycles since reset pin release and since the last interrupt cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            live_q <= 3'h0;
            ev_q <= 3'h0;
        end else begin
            live_q <= !reset_pin_n ? 3'h0 : live_q + {2'h0, live_q != 3'h7};
            if (pin_in != $past(pin_in) || wr_stb || rd_ack_phase || !reset_pin_n) begin
                ev_q <= 3'h0;
            end else begin
                ev_q <= ev_q + {2'h0, ev_q != 3'h7};
            end
        end
    end
    // Command values outside the map
    assign unl = !(ptr_data inside {[8'h00:8'h03], [8'h40:8'h46], 8'h4f});
    // ----------------------------------------
    // Sequences and assertions
    // ----------------------------------------
    sequence ptr_rd(logic [7:0] p);
        ptr_wr && ptr_data == p ##1 rd_stb;
    endsequence
    sequence ptr_wrd(logic [7:0] p);
        ptr_wr && ptr_data == p ##1 wr_stb;
    endsequence
    reset_vals_a: assert property ($fell(rst) |-> rd_data == 8'h00 && pin_out == '1
        && pull_up == '1 && strength_code == '1 && !int_n_oe) else $error("bad reset values");
    rd_hold_a: assert property (live_q == 3'h7 && !$past(rd_stb) |-> $stable(rd_data))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (ptr_wr && unl ##1 rd_stb |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    od_reserved_a: assert property (ptr_rd(8'h4f) |=> rd_data[7:1] == 7'h00)
        else $error("reserved stage bits not zero");
    out_drive_a: assert property (ptr_wrd(8'h01) |=> pin_out == $past(wr_data))
        else $error("output level not driven");
    strength_hi_a: assert property (ptr_wrd(8'h41) |=> strength_code[15:8] == $past(wr_data))
        else $error("high strength codes wrong");
    strength_lo_a: assert property (ptr_wrd(8'h40) |=> strength_code[7:0] == $past(wr_data))
        else $error("low strength codes wrong");
    pull_dir_a: assert property (ptr_wrd(8'h44) |=> pull_up == $past(wr_data))
        else $error("pull direction wrong");
    int_cause_a: assert property ($rose(int_n_oe) |-> ev_q <= 3'h5)
        else $error("interrupt rose without cause");
    int_clear_a: assert property ($fell(int_n_oe) |-> ev_q <= 3'h5)
        else $error("interrupt fell without cause");
endmodule
bind gex_regs gex_chk #(.PINS(PINS), .SYNC_STAGES(SYNC_STAGES)) i_chk (.clk(clk), .rst(rst),
    .reset_pin_n(reset_pin_n), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_ack_phase(rd_ack_phase), .rd_data(rd_data),
    .pin_in(pin_in), .pin_out(pin_out), .pull_up(pull_up), .strength_code(strength_code),
    .int_n_oe(int_n_oe));

// ===== test/gex_host_mdl.sv
// Bus master model issuing command, data, read and acknowledge steps
`timescale 1ns/1ps
module gex_host_mdl (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output logic scl,
    output logic ptr_wr,
    output logic [7:0] ptr_data,
    output logic wr_stb,
    output logic [7:0] wr_data,
    output logic rd_stb,
    output logic rd_ack_phase
);
    // Idle bus, serial clock parked high
    initial begin
        {scl, ptr_wr, wr_stb, rd_stb, rd_ack_phase} = 5'h10;
        ptr_data = 8'h5a;
        wr_data = 8'ha5;
    end
    // Command byte, then one data byte written or read
    task automatic xfer(input logic [7:0] p, input logic wr, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        ptr_wr <= 1'b1;
        ptr_data <= p;
        @(posedge clk);
        ptr_wr <= 1'b0;
        ptr_data <= ~p;
        wr_stb <= wr;
        rd_stb <= !wr;
        wr_data <= d;
        @(posedge clk);
        {wr_stb, rd_stb} <= 2'h0;
        wr_data <= ~d;
        @(posedge clk);
        #1 q = rd_data;
    endtask
    // Acknowledge bit of a read byte, one 80 ns clock pulse
    task automatic ack_bit();
        @(posedge clk);
        rd_ack_phase <= 1'b1;
        #7 scl = 1'b0;
        #80 scl = 1'b1;
        #80 scl = 1'b0;
        @(posedge clk);
        rd_ack_phase <= 1'b0;
        #7 scl = 1'b1;
    endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the GPIO expander register block
`timescale 1ns/1ps
module tb;
    import gex_pkg::*;
    logic clk, rst, reset_pin_n, scl, ptr_wr, wr_stb, rd_stb, rd_ack_phase, int_n_oe;
    logic [7:0] ptr_data, wr_data, rd_data, pin_in, pin_out, pin_oe, pull_connect, pull_up;
    logic [15:0] strength_code;
    logic [31:0] lfsr_q;
    logic [7:0] ext_q, q, d, b, c;
    logic [7:0] val [12];
    logic [7:0] offs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
        8'h45, 8'h46, 8'h4f};
    logic [7:0] rstv [12] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff,
        8'hff, 8'h00, 8'h00};
    logic [7:0] unm [10] = '{8'h00, 8'h46, 8'h04, 8'h07, 8'h10, 8'h3f, 8'h47, 8'h4e, 8'h50,
        8'h7f};
    int mismatches, n_tests, i, r;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Wire level: driven pins show the design, others the outside world
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_q);
    gex_regs i_dut (.clk(clk), .rst(rst), .ce(1'b1), .reset_pin_n(reset_pin_n), .scl(scl),
        .ptr_wr(ptr_wr), .ptr_data(ptr_data), .wr_stb(wr_stb), .wr_data(wr_data),
        .rd_stb(rd_stb), .rd_ack_phase(rd_ack_phase), .rd_data(rd_data), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_connect(pull_connect), .pull_up(pull_up),
        .strength_code(strength_code), .int_n_oe(int_n_oe));
    gex_host_mdl i_mst (.clk(clk), .rd_data(rd_data), .scl(scl), .ptr_wr(ptr_wr),
        .ptr_data(ptr_data), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_ack_phase(rd_ack_phase));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic rnd(output logic [7:0] v);
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        v = lfsr_q[7:0];
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded wait for the interrupt line level
    task automatic int_is(input logic v);
        for (int k = 0; k < 8 && int_n_oe !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0000, int_n_oe}, {15'h0000, v});
        if (int_n_oe !== v) stop_test();
    endtask
    task automatic set_ext(input logic [7:0] v);
        @(posedge clk);
        ext_q <= v;
    endtask
    task automatic reset_pin();
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        lfsr_q = 32'h6f412ac5;
        {rst, reset_pin_n, mismatches, n_tests} = {2'b10, 32'd0, 32'd0};
        rnd(d);
        ext_q = d;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reset_pin();
        // Reset values, refused writes, unmapped places
        for (i = 0; i < 12; i++) begin
            i_mst.xfer(offs[i], 1'b0, 8'h00, q);
            chk({8'h00, q}, {8'h00, (i == 0) ? ext_q : rstv[i]});
        end
        chk({pin_oe, pull_connect}, 16'h0000);
        for (i = 0; i < 10; i++) begin
            i_mst.xfer(unm[i], 1'b1, ~ext_q, q);
            i_mst.xfer(unm[i], 1'b0, 8'h00, q);
            chk({8'h00, q}, {8'h00, (i == 0) ? ext_q : 8'h00});
        end
        $display("test reset_map done");
        // Random writes with read back and pin controls
        for (r = 0; r < 4; r++) begin
            for (i = 1; i < 12; i++) begin
                rnd(d);
                d = (i == 11) ? {d[7:1], r[0]} : d;
                val[i] = (i == 11) ? {7'h00, d[0]} : d;
                i_mst.xfer(offs[i], 1'b1, d, q);
            end
            for (i = 1; i < 12; i++) begin
                i_mst.xfer(offs[i], 1'b0, 8'h00, q);
                if (i != 10) chk({8'h00, q}, {8'h00, val[i]});
            end
            chk({pin_out, pull_up}, {val[1], val[8]});
            chk(strength_code, {val[5], val[4]});
            chk({pin_oe, pull_connect}, {~val[3] & ~({8{val[11][0]}} & val[1]),
                val[7] & ~({8{val[11][0]}} & ~val[3])});
        end
        i_mst.xfer(8'h45, 1'b1, 8'hff, q);
        i_mst.xfer(8'h46, 1'b0, 8'h00, q);
        chk({8'h00, q}, 16'h0000);
        reset_pin();
        i_mst.xfer(8'h01, 1'b0, 8'h00, q);
        chk({8'h00, q}, 16'h00ff);
        $display("test readback done");
        // Non-latched change, mask, clear at acknowledge, output pins
        rnd(d);
        b = 8'h01 << d[2:0];
        c = 8'h01 << ((d[2:0] + 3'h3) & 3'h7);
        i_mst.xfer(8'h45, 1'b1, ~b, q);
        set_ext(ext_q ^ b);
        int_is(1'b1);
        i_mst.xfer(8'h46, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, b});
        set_ext(ext_q ^ b);
        int_is(1'b0);
        set_ext(ext_q ^ b);
        int_is(1'b1);
        i_mst.xfer(8'h00, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, ext_q});
        i_mst.ack_bit();
        int_is(1'b0);
        set_ext(ext_q ^ c);
        repeat (6) @(posedge clk);
        int_is(1'b0);
        i_mst.xfer(8'h45, 1'b1, ~(b | c), q);
        int_is(1'b1);
        i_mst.xfer(8'h45, 1'b1, ~b, q);
        int_is(1'b0);
        i_mst.xfer(8'h03, 1'b1, ~b, q);
        i_mst.xfer(8'h01, 1'b1, ~b, q);
        i_mst.xfer(8'h02, 1'b1, 8'hff, q);
        i_mst.xfer(8'h00, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, ~ext_q & ~b});
        int_is(1'b0);
        $display("test live_irq done");
        // Latched and non-latched pins together, then unlatching
        reset_pin();
        i_mst.xfer(8'h42, 1'b1, b, q);
        i_mst.xfer(8'h45, 1'b1, ~(b | c), q);
        set_ext(ext_q ^ (b | c));
        int_is(1'b1);
        set_ext(ext_q ^ (b | c));
        repeat (6) @(posedge clk);
        int_is(1'b1);
        i_mst.xfer(8'h00, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, ext_q ^ b});
        i_mst.ack_bit();
        int_is(1'b0);
        i_mst.xfer(8'h00, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, ext_q});
        set_ext(ext_q ^ b);
        int_is(1'b1);
        set_ext(ext_q ^ b);
        i_mst.xfer(8'h42, 1'b1, 8'h00, q);
        repeat (6) @(posedge clk);
        int_is(1'b1);
        i_mst.xfer(8'h00, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, ext_q});
        i_mst.ack_bit();
        int_is(1'b0);
        $display("test latch_irq done");
        stop_test();
    end
endmodule
